// ### wpf_pkg.sv
package wpf_pkg;
    // ============================================================
    // register map (word indices; byte address is index times four)
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] CFG_IDX = 12'h0134;
    localparam logic [11:0] STATUS_IDX = 12'h0135;
    localparam logic [11:0] IRQ_STATUS_IDX = 12'h0136;
    localparam logic [11:0] IRQ_MASK_IDX = 12'h0137;
    localparam logic [15:0] CFG_RESET = 16'h1000;
    localparam logic [15:0] CFG_RW_MASK = 16'hF7FF;
    // ============================================================
    // config fields
    localparam int unsigned CFG_LEVEL_CLEAR = 11;
    localparam int unsigned CFG_WIDTH_HI = 10;
    localparam int unsigned CFG_WIDTH_LO = 9;
    localparam int unsigned CFG_STYLE = 8;
    localparam int unsigned CFG_EXT_RX = 7;
    localparam int unsigned CFG_UCAST_EN = 4;
    localparam int unsigned CFG_BCAST_EN = 2;
    localparam int unsigned CFG_PATTERN_EN = 1;
    localparam int unsigned CFG_MAGIC_EN = 0;
    // ============================================================
    // status fields
    localparam int unsigned ST_DELIMITER_ERROR_FLAG = 7;
    localparam int unsigned ST_BAD_CRC = 6;
    localparam int unsigned ST_UCAST = 4;
    localparam int unsigned ST_BCAST = 2;
    localparam int unsigned ST_PATTERN = 1;
    localparam int unsigned ST_MAGIC = 0;
    localparam logic [7:0] ST_USED_MASK = 8'hD7;
    // ============================================================
    // pulse widths in clock cycles
    localparam logic [6:0] PULSE_BASE = 7'h08;
    // ============================================================
    // wake output states
    typedef enum logic [1:0] {
        WPF_IDLE = 2'b00,
        WPF_PULSE = 2'b01,
        WPF_LEVEL = 2'b10
    } wpf_state_e;
endpackage

// ### wpf_top.sv
// Behaviour
// - wake pin pulses when style bit is zero, holds level when one
// - pulse width field selects 8, 16, 32 or 64 clock cycles
// - level held until level-clear bit written; write deasserts, bit self-clears
// - unicast wake enable asserts wake pin on each unicast packet
// - broadcast wake enable asserts wake pin on each broadcast packet
// - pattern wake enable asserts wake pin on pattern-match packet
// - magic wake enable asserts wake pin on magic packet
// - status bit 6 sets on bad CRC packet, clears on status read
// - status bit 4 sets on unicast packet, clears on status read
// - status bit 2 sets on broadcast packet, clears on status read
// - status bit 1 sets on pattern match, clears on status read
// - status bit 0 sets on magic packet, clears on status read
module wpf_top (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [13:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_rx_unicast,
    input wire logic i_rx_broadcast,
    input wire logic i_rx_pattern,
    input wire logic i_rx_magic,
    input wire logic i_rx_bad_crc,
    input wire logic i_rx_delimiter_error_flag,
    output logic o_wake,
    output logic o_irq
);
    // ============================================================
    // bus decode
    logic [11:0] word_idx;
    logic bus_req;
    logic hit_cfg, hit_st, hit_ist, hit_msk;
    logic ack_r, ack_nxt;
    logic wreq_r, wreq_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [15:0] cfg_r, cfg_nxt;
    logic [7:0] status_r, status_nxt;
    logic [7:0] ist_r, ist_nxt;
    logic [7:0] msk_r, msk_nxt;
    logic irq_r, irq_nxt;
    logic [7:0] events;
    logic [7:0] wake_ev;
    logic wake_trig;
    logic do_wr, do_rd;
    logic [15:0] wmask;
    wpf_pkg::wpf_state_e state_r, state_nxt;
    logic [6:0] cnt_r, cnt_nxt;
    logic wake_r, wake_nxt;

    assign word_idx = i_avs_address[13:2];
    assign bus_req = (i_avs_read | i_avs_write) & ~ack_r;
    assign hit_cfg = (word_idx == wpf_pkg::CFG_IDX);
    assign hit_st = (word_idx == wpf_pkg::STATUS_IDX);
    assign hit_ist = (word_idx == wpf_pkg::IRQ_STATUS_IDX);
    assign hit_msk = (word_idx == wpf_pkg::IRQ_MASK_IDX);
    assign do_wr = bus_req & i_avs_write;
    assign do_rd = bus_req & i_avs_read;
    assign wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    function automatic logic [6:0] pulse_len(input logic [1:0] sel);
        pulse_len = wpf_pkg::PULSE_BASE << sel;
    endfunction

    // ============================================================
    // event vector in status layout
    always_comb begin
        events = 8'h00;
        events[wpf_pkg::ST_DELIMITER_ERROR_FLAG] = i_rx_delimiter_error_flag;
        events[wpf_pkg::ST_BAD_CRC] = i_rx_bad_crc;
        events[wpf_pkg::ST_UCAST] = i_rx_unicast;
        events[wpf_pkg::ST_BCAST] = i_rx_broadcast;
        events[wpf_pkg::ST_PATTERN] = i_rx_pattern;
        events[wpf_pkg::ST_MAGIC] = i_rx_magic;
        wake_ev = 8'h00;
        wake_ev[wpf_pkg::ST_UCAST] = i_rx_unicast & cfg_r[wpf_pkg::CFG_UCAST_EN];
        wake_ev[wpf_pkg::ST_BCAST] = i_rx_broadcast & cfg_r[wpf_pkg::CFG_BCAST_EN];
        wake_ev[wpf_pkg::ST_PATTERN] = i_rx_pattern & cfg_r[wpf_pkg::CFG_PATTERN_EN];
        wake_ev[wpf_pkg::ST_MAGIC] = i_rx_magic & cfg_r[wpf_pkg::CFG_MAGIC_EN];
        wake_trig = |wake_ev;
    end

    // ============================================================
    // registers and bus answer
    always_comb begin
        ack_nxt = bus_req;
        wreq_nxt = ~bus_req;
        rdata_nxt = rdata_r;
        cfg_nxt = cfg_r;
        status_nxt = status_r;
        ist_nxt = ist_r;
        msk_nxt = msk_r;
        if (do_rd) begin
            rdata_nxt = 32'h0000_0000;
            if (hit_cfg) begin
                rdata_nxt[15:0] = cfg_r;
            end else if (hit_st) begin
                rdata_nxt[7:0] = status_r;
                status_nxt = 8'h00;
            end else if (hit_ist) begin
                rdata_nxt[7:0] = ist_r;
            end else if (hit_msk) begin
                rdata_nxt[7:0] = msk_r;
            end
        end
        if (do_wr && hit_cfg) begin
            cfg_nxt = (cfg_r & ~(wmask & wpf_pkg::CFG_RW_MASK))
                    | (i_avs_writedata[15:0] & wmask & wpf_pkg::CFG_RW_MASK);
        end
        if (do_wr && hit_ist && i_avs_byteenable[0]) begin
            ist_nxt = ist_r & ~i_avs_writedata[7:0];
        end
        if (do_wr && hit_msk && i_avs_byteenable[0]) begin
            msk_nxt = i_avs_writedata[7:0] & wpf_pkg::ST_USED_MASK;
        end
        status_nxt = status_nxt | events;
        ist_nxt = ist_nxt | events;
        irq_nxt = |(ist_nxt & msk_nxt);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_r <= 1'b0;
            wreq_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            cfg_r <= wpf_pkg::CFG_RESET;
            status_r <= 8'h00;
            ist_r <= 8'h00;
            msk_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
            wreq_r <= wreq_nxt;
            rdata_r <= rdata_nxt;
            cfg_r <= cfg_nxt;
            status_r <= status_nxt;
            ist_r <= ist_nxt;
            msk_r <= msk_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign o_avs_waitrequest = wreq_r;
    assign o_avs_readdata = rdata_r;
    assign o_irq = irq_r;

    // ============================================================
    // wake output
    logic lvl_clr;
    assign lvl_clr = do_wr && hit_cfg && i_avs_byteenable[1]
                   && i_avs_writedata[wpf_pkg::CFG_LEVEL_CLEAR];

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        wake_nxt = wake_r;
        case (state_r)
            wpf_pkg::WPF_IDLE: begin
                wake_nxt = 1'b0;
            end
            wpf_pkg::WPF_PULSE: begin
                if (cnt_r <= 7'h01) begin
                    state_nxt = wpf_pkg::WPF_IDLE;
                    wake_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 7'h01;
                end
            end
            wpf_pkg::WPF_LEVEL: begin
                if (lvl_clr) begin
                    state_nxt = wpf_pkg::WPF_IDLE;
                    wake_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = wpf_pkg::WPF_IDLE;
                wake_nxt = 1'b0;
            end
        endcase
        if (wake_trig) begin
            wake_nxt = 1'b1;
            if (cfg_r[wpf_pkg::CFG_STYLE]) begin
                state_nxt = wpf_pkg::WPF_LEVEL;
            end else begin
                state_nxt = wpf_pkg::WPF_PULSE;
                cnt_nxt = pulse_len(cfg_r[wpf_pkg::CFG_WIDTH_HI:wpf_pkg::CFG_WIDTH_LO]);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= wpf_pkg::WPF_IDLE;
            cnt_r <= 7'h00;
            wake_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign o_wake = wake_r;
endmodule // wpf_top

// ### wpf_top_asserts.sv
module wpf_top_chk (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_rx_unicast,
    input wire logic i_rx_broadcast,
    input wire logic i_rx_pattern,
    input wire logic i_rx_magic,
    input wire logic i_rx_bad_crc,
    input wire logic i_rx_delimiter_error_flag,
    input wire logic o_wake,
    input wire logic o_irq
);
    // ============================================================
    // bus answer, wake and interrupt checks
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    logic wake_ev;
    assign wake_ev = i_rx_unicast | i_rx_broadcast | i_rx_pattern | i_rx_magic;
    sequence req_taken; (i_avs_read | i_avs_write) && o_avs_waitrequest; endsequence
    sequence wake_starts; $rose(o_wake); endsequence
    bus_answer_a: assert property (req_taken |=> !o_avs_waitrequest)
        else $error("request not answered after one wait cycle");
    answer_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("answer held longer than one cycle");
    bus_idle_a: assert property (!(i_avs_read | i_avs_write) |=> o_avs_waitrequest)
        else $error("answer without request");
    upper_zero_a: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000)
        else $error("upper read lanes not zero");
    wake_cause_a: assert property (wake_starts |-> $past(wake_ev))
        else $error("wake rose without a packet event");
    wake_min_a: assert property (wake_starts |-> o_wake [*8])
        else $error("wake shorter than eight cycles");
    irq_cause_a: assert property ($rose(o_irq) |-> $past(wake_ev | i_rx_bad_crc | i_rx_delimiter_error_flag | i_avs_write))
        else $error("interrupt rose without cause");
    irq_drop_a: assert property ($fell(o_irq) |-> $past(i_avs_write))
        else $error("interrupt fell without a write");
endmodule // wpf_top_chk
bind wpf_top wpf_top_chk i_wpf_top_chk (.*);

// ### wpf_wake_host.sv
module wpf_wake_host (
    input wire logic i_sys_clk,
    input wire logic i_wake,
    output int o_len,
    output int o_rises
);
    // ============================================================
    // measures each high run of the wake pin
    int run_r = 0;
    int len_r = 0;
    int rises_r = 0;
    assign o_len = len_r;
    assign o_rises = rises_r;
    always @(posedge i_sys_clk) begin
        if (i_wake === 1'b1) begin
            if (run_r == 0) rises_r <= rises_r + 1;
            run_r <= run_r + 1;
        end else begin
            if (run_r != 0) len_r <= run_r;
            run_r <= 0;
        end
    end
endmodule // wpf_wake_host

// ### test_wake_packet_filter.sv
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_wake_packet_filter;
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // stimulus and checks
    logic clk = 0, nrst = 0, rd = 0, wr = 0, wq, wake, irq;
    logic [13:0] adr = 14'h0000;
    logic [31:0] wd = 32'h0000_0000, q, rdata;
    logic [7:0] ev = 8'h00;
    int mismatches = 0, num_checks = 0, cyc = 0, len, rises;
    int bits[6] = '{0, 1, 2, 4, 6, 7};
    always #2.5 clk = ~clk;
    wpf_top i_wpf_top (.i_sys_clk(clk), .i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h3), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wq), .i_rx_unicast(ev[4]), .i_rx_broadcast(ev[2]), .i_rx_pattern(ev[1]),
        .i_rx_magic(ev[0]), .i_rx_bad_crc(ev[6]), .i_rx_delimiter_error_flag(ev[7]), .o_wake(wake), .o_irq(irq));
    wpf_wake_host i_wpf_wake_host (.i_sys_clk(clk), .i_wake(wake), .o_len(len), .o_rises(rises));
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [13:0] a, input logic [15:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {16'h0000, d};
        do begin @(posedge clk); end while (wq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev[b] <= 1'b0;
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        while (wake === 1'b1) begin @(posedge clk); end
        @(posedge clk);
    endtask
    task automatic t_regs;
        bus(0, 14'h04D0, 16'h0000); `CHK(q, 32'h0000_1000)
        bus(0, 14'h04D4, 16'h0000); `CHK(q, 32'h0000_0000)
        bus(1, 14'h0000, 16'hFFFF);
        bus(0, 14'h0000, 16'h0000); `CHK(q, 32'h0000_0000)
        $display("t_regs done");
    endtask
    task automatic t_status;
        foreach (bits[i]) begin
            pulse(bits[i]);
            bus(0, 14'h04D4, 16'h0000); `CHK(q, 32'h0000_0001 << bits[i])
            bus(0, 14'h04D4, 16'h0000); `CHK(q, 32'h0000_0000)
        end
        `CHK(rises, 0)
        $display("t_status done");
    endtask
    task automatic t_pulse;
        for (int i = 0; i < 4; i++) begin
            bus(1, 14'h04D0, 16'h0080 | (16'(i) << 9) | (16'h0001 << bits[i]));
            pulse(bits[i]);
            settle;
            `CHK(len, 8 << i)
            `CHK(rises, i + 1)
        end
        bus(1, 14'h04D0, 16'h0001);
        pulse(0);
        repeat (3) @(posedge clk);
        pulse(0);
        settle; `CHK(len, 12)
        $display("t_pulse done");
    endtask
    task automatic t_level;
        bus(1, 14'h04D0, 16'h0111);
        pulse(4);
        repeat (100) @(posedge clk); `CHK(wake, 1'b1)
        bus(1, 14'h04D0, 16'h0911);
        repeat (2) @(posedge clk); `CHK(wake, 1'b0)
        bus(0, 14'h04D0, 16'h0000); `CHK(q, 32'h0000_0111)
        $display("t_level done");
    endtask
    task automatic t_irq;
        bus(1, 14'h04D8, 16'h00D7);
        bus(1, 14'h04DC, 16'h0004);
        pulse(0);
        repeat (2) @(posedge clk); `CHK(irq, 1'b0)
        pulse(2);
        repeat (2) @(posedge clk); `CHK(irq, 1'b1)
        bus(1, 14'h04DC, 16'h0000);
        repeat (2) @(posedge clk); `CHK(irq, 1'b0)
        bus(1, 14'h04DC, 16'h0004);
        repeat (2) @(posedge clk); `CHK(irq, 1'b1)
        bus(1, 14'h04D8, 16'h0004);
        repeat (2) @(posedge clk); `CHK(irq, 1'b0)
        $display("t_irq done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin mismatches++; complete_run; end
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_status;
        t_pulse;
        t_level;
        t_irq;
        complete_run;
    end
endmodule // test_wake_packet_filter
